/* verilog/asc_pkg.sv */
`default_nettype none
package asc_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [11:0] ASC_CTRL_OFS   = 12'h000;
	localparam logic [11:0] ASC_STATUS_OFS = 12'h004;
	localparam logic [11:0] ASC_TERR_OFS   = 12'h008;
	localparam logic [11:0] ASC_LIMIT_OFS  = 12'h00c;

	// control field positions
	localparam int ASC_CTRL_TELECOM_BIT = 0;
	localparam int ASC_CTRL_PSUA_BIT    = 1;
	localparam int ASC_CTRL_PSUB_BIT    = 2;
	localparam int ASC_CTRL_ESF_BIT     = 3;
	localparam int ASC_CTRL_SSMSEL_BIT  = 4;
	localparam int ASC_CTRL_W           = 5;
	localparam logic [ASC_CTRL_W-1:0] ASC_CTRL_RST = 5'h00;

	// status field positions
	localparam int ASC_ST_CRIT_BIT  = 16;
	localparam int ASC_ST_MAJOR_BIT = 17;
	localparam int ASC_ST_MINOR_BIT = 18;

	// fault word bit positions
	localparam int ASC_F_DAC_RANGE  = 0;
	localparam int ASC_F_NO_SIGNAL  = 1;
	localparam int ASC_F_FPGA_CFG   = 2;
	localparam int ASC_F_FLASH_WR   = 3;
	localparam int ASC_F_LOCAL_OSC  = 4;
	localparam int ASC_F_TIME_IN    = 5;
	localparam int ASC_F_NO_POLL    = 6;
	localparam int ASC_F_ANTENNA    = 7;
	localparam int ASC_F_PSU_A      = 8;
	localparam int ASC_F_PSU_B      = 9;
	localparam int ASC_F_WANDER     = 10;
	localparam int ASC_STD_FAULTS   = 10;
	localparam int ASC_FAULT_W      = 11;

	// wander threshold, fixed at build time
	localparam int          ASC_WANDER_LIMIT_US = 1;
	localparam logic [31:0] ASC_WANDER_LIMIT_NS =
		32'(ASC_WANDER_LIMIT_US * 1000);

	// sync-status message codes
	localparam logic [15:0] ASC_SSM_SYNC_OK   = 16'hff20;
	localparam logic [15:0] ASC_SSM_DONT_USE  = 16'hff0c;

	// control register fields
	typedef struct packed {
		logic ssm_sel;
		logic esf_mode;
		logic psu_b_fitted;
		logic psu_a_fitted;
		logic telecom_fitted;
	} asc_ctrl_s;

	// severity outputs
	typedef struct packed {
		logic critical;
		logic major;
		logic minor;
	} asc_sev_s;

endpackage
`default_nettype wire

/* verilog/asc_classifier.sv */
// Our own choices: the placing of the registers and the APB slave port.
`default_nettype none
// Overview of operation
// - Configuration, flash write and local oscillator faults are critical.
// - No-signal timeout, time input and no-polling faults are major.
// - Control over-range, antenna and fitted supply A faults are minor.
// - A supply B fault is minor when that supply option is fitted.
// - A serious hardware problem on either module is always critical.
// - Eight standard faults are always watched; supplies only when fitted, wander only with telecom.
// - Out of lock, drift beyond the threshold sets the major wander fault.
// - Crossing the threshold drives relays and status bits at once.
// - The wander threshold is a fixed constant, not software writable.
// - Major alarm with status option in extended mode sends do-not-use.
module asc_classifier
	import asc_pkg::*;
(
	// apb slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// fault pins, asynchronous
	input  wire logic [9:0]  fault_pins,
	input  wire logic        clock_mod_hw_err,
	input  wire logic        cpu_mod_hw_err,
	input  wire logic        signal_lock,
	// accumulated time error from same-clock holdover logic
	input  wire logic [31:0] time_err_ns,
	// alarm relays and status message
	output asc_sev_s         alarm_q,
	output logic [ASC_FAULT_W-1:0] fault_word_field,
	output logic [15:0]      ssm_msg_q
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [12:0] sync1_q;
	logic [12:0] sync2_q;

	// first stage read only by the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= 13'h0000;
			sync2_q <= 13'h0000;
		end else begin
			sync1_q <= {signal_lock, cpu_mod_hw_err, clock_mod_hw_err,
				fault_pins};
			sync2_q <= sync1_q;
		end
	end

	logic [9:0] std_f;
	logic       hw_err;
	logic       locked;
	assign std_f  = sync2_q[9:0];
	assign hw_err = sync2_q[10] | sync2_q[11];
	assign locked = sync2_q[12];

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	asc_ctrl_s ctrl_q;
	logic      wr_en;
	logic      rd_map;
	assign wr_en = psel & penable & pwrite;

	// only the option bits are writable; threshold has no storage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= asc_ctrl_s'(ASC_CTRL_RST);
		end else if (wr_en && paddr == ASC_CTRL_OFS) begin
			ctrl_q <= asc_ctrl_s'(pwdata[ASC_CTRL_W-1:0]);
		end
	end

	// ---------------------------------------------------------------
	// wander monitor
	// ---------------------------------------------------------------
	logic wander_d;
	// compare against fixed limit only out of lock with telecom fitted
	always_comb begin
		wander_d = ctrl_q.telecom_fitted & ~locked
			& (time_err_ns > ASC_WANDER_LIMIT_NS);
	end

	// ---------------------------------------------------------------
	// fault word and classification
	// ---------------------------------------------------------------
	logic [ASC_FAULT_W-1:0] faults;
	always_comb begin
		faults = {wander_d, std_f};
		// optional supplies count only when fitted
		faults[ASC_F_PSU_A] = std_f[ASC_F_PSU_A] & ctrl_q.psu_a_fitted;
		faults[ASC_F_PSU_B] = std_f[ASC_F_PSU_B] & ctrl_q.psu_b_fitted;
	end

	asc_sev_s sev_d;
	always_comb begin
		sev_d.critical = faults[ASC_F_FPGA_CFG] | faults[ASC_F_FLASH_WR]
			| faults[ASC_F_LOCAL_OSC]
			| hw_err;
		sev_d.major = faults[ASC_F_NO_SIGNAL] | faults[ASC_F_TIME_IN]
			| faults[ASC_F_NO_POLL]
			| faults[ASC_F_WANDER];
		sev_d.minor = faults[ASC_F_DAC_RANGE] | faults[ASC_F_ANTENNA]
			| faults[ASC_F_PSU_A]
			| faults[ASC_F_PSU_B];
	end

	// one register stage, same edge for relays and status bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_q          <= '0;
			fault_word_field <= '0;
		end else begin
			alarm_q          <= sev_d;
			fault_word_field <= faults;
		end
	end

	// ---------------------------------------------------------------
	// sync-status message
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ssm_msg_q <= ASC_SSM_SYNC_OK;
		end else if (sev_d.major && ctrl_q.ssm_sel && ctrl_q.esf_mode) begin
			ssm_msg_q <= ASC_SSM_DONT_USE;
		end else begin
			ssm_msg_q <= ASC_SSM_SYNC_OK;
		end
	end

	// ---------------------------------------------------------------
	// apb read side, zero wait states
	// ---------------------------------------------------------------
	assign pready = 1'b1;
	always_comb begin
		rd_map = 1'b1;
		prdata = 32'h0000_0000;
		case (paddr)
			ASC_CTRL_OFS:   prdata = {27'h0, ctrl_q};
			ASC_STATUS_OFS: begin
				prdata[ASC_FAULT_W-1:0]  = fault_word_field;
				prdata[ASC_ST_CRIT_BIT]  = alarm_q.critical;
				prdata[ASC_ST_MAJOR_BIT] = alarm_q.major;
				prdata[ASC_ST_MINOR_BIT] = alarm_q.minor;
			end
			ASC_TERR_OFS:   prdata = time_err_ns;
			ASC_LIMIT_OFS:  prdata = ASC_WANDER_LIMIT_NS;
			default:        rd_map = 1'b0;
		endcase
	end
	// unmapped address answers with an error in the access phase
	assign pslverr = psel & penable & ~rd_map;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	crit_osc_a: assert property (
		sync2_q[ASC_F_LOCAL_OSC] |=> alarm_q.critical)
		else $error("oscillator fault not critical");
	major_poll_a: assert property (
		sync2_q[ASC_F_NO_POLL] |=> alarm_q.major)
		else $error("polling fault not major");
	minor_ant_a: assert property (
		sync2_q[ASC_F_ANTENNA] |=> alarm_q.minor)
		else $error("antenna fault not minor");
	psub_gate_a: assert property (
		!ctrl_q.psu_b_fitted |=> !fault_word_field[ASC_F_PSU_B])
		else $error("unfitted supply b flagged");
	hw_crit_a: assert property (
		(sync2_q[10] || sync2_q[11]) |=> alarm_q.critical)
		else $error("hardware problem not critical");
	wander_gate_a: assert property (
		!$past(ctrl_q.telecom_fitted) |-> !fault_word_field[ASC_F_WANDER])
		else $error("wander flagged without telecom");
	wander_set_a: assert property (
		(ctrl_q.telecom_fitted && !locked
			&& time_err_ns > 32'd1000) |=> alarm_q.major)
		else $error("wander did not raise major");
	wander_edge_a: assert property (
		$rose(wander_d) |=> fault_word_field[ASC_F_WANDER]
			&& (ssm_msg_q == ASC_SSM_DONT_USE
			|| !$past(ctrl_q.ssm_sel) || !$past(ctrl_q.esf_mode)))
		else $error("wander crossing delayed");
	limit_ro_a: assert property (
		(psel && !penable && paddr == ASC_LIMIT_OFS) ##1 penable
			|-> prdata == 32'd1000)
		else $error("threshold readback wrong");
	ssm_dnu_a: assert property (
		alarm_q.major && $past(ctrl_q.ssm_sel)
			&& $past(ctrl_q.esf_mode) |-> ssm_msg_q == ASC_SSM_DONT_USE)
		else $error("do-not-use code missing");
	ssm_norm_a: assert property (
		!(alarm_q.major && $past(ctrl_q.ssm_sel) && $past(ctrl_q.esf_mode))
			|-> ssm_msg_q == ASC_SSM_SYNC_OK)
		else $error("do-not-use code without cause");
	minor_psua_a: assert property (
		(std_f[ASC_F_PSU_A] && ctrl_q.psu_a_fitted) |=> alarm_q.minor)
		else $error("fitted supply a fault not minor");
	wander_clr_a: assert property (
		locked |=> !fault_word_field[ASC_F_WANDER])
		else $error("wander held while locked");
	sev_clear_a: assert property (
		(std_f == 10'h000 && !hw_err && !wander_d) |=> alarm_q == 3'h0)
		else $error("severity set with no fault");
	sev_hold_a: assert property (
		(std_f[ASC_F_FLASH_WR] [*3]) |=> alarm_q.critical [*1])
		else $error("critical dropped while fault held");

	wander_cv: cover property ($rose(alarm_q.major) && fault_word_field[10]);
	dnu_cv:    cover property (ssm_msg_q == ASC_SSM_DONT_USE);
	crit_cv:   cover property (alarm_q.critical && alarm_q.minor);
	err_cv:    cover property (pslverr);

endmodule
`default_nettype wire

/* bench/asc_drift_model.sv */
`default_nettype none
// holdover source: error grows 1 ns a cycle while out of lock,
// so the bench can hit the threshold on an exact cycle
module asc_drift_model (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// lock in, error out
	input  wire logic        locked,
	output logic      [31:0] err_q
);
	timeunit 1ns;
	timeprecision 1ps;
	// relock wipes the accumulated error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			err_q <= '0;
		else if (locked)
			err_q <= '0;
		else
			err_q <= err_q + 32'h1;
	end
endmodule
`default_nettype wire

/* bench/alarm_severity_classifier_tb_top.sv */
`default_nettype none
module alarm_severity_classifier_tb_top
	import asc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic locked = 1, hw_a = 0, hw_b = 0, pready, pslverr, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, terr, rd;
	logic [9:0]  pins = '0;
	logic [15:0] ssm;
	logic [10:0] fw;
	asc_sev_s    alarm_q;
	int          num_errors = 0, n_checks = 0;
	logic [2:0]  sev_t [0:9] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h4,
		3'h2, 3'h2, 3'h1, 3'h1, 3'h1};
	// 200 MHz
	always #2.5 pclk = ~pclk;
	asc_drift_model i_drift (.pclk(pclk), .presetn(presetn),
		.locked(locked), .err_q(terr));
	asc_classifier i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fault_pins(pins), .clock_mod_hw_err(hw_a),
		.cpu_mod_hw_err(hw_b), .signal_lock(locked), .time_err_ns(terr),
		.alarm_q(alarm_q), .fault_word_field(fw), .ssm_msg_q(ssm));
	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task test_done;
		if (num_errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, string m);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %0t %s %h/%h", $time, m, got, exp);
		end
	endtask
	// request held until pready is seen at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 16) begin num_errors++; test_done(); end
		rd = prdata; err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// two synchroniser flops plus the output register
	task wait3;
		repeat (3) @(posedge pclk);
		#1;
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task t_regs;
		chk(ssm, 32'hff20, "ssm reset");
		apb(1'b1, ASC_LIMIT_OFS, 32'h5);
		apb(1'b0, ASC_LIMIT_OFS, '0);
		chk(rd, 32'h3e8, "limit fixed");
		apb(1'b0, 12'h010, '0);
		chk({rd[30:0], err}, 32'h1, "unmapped");
		apb(1'b0, ASC_CTRL_OFS, '0);
		chk(rd, 32'h0, "ctrl reset");
	endtask
	task t_table;
		apb(1'b1, ASC_CTRL_OFS, 32'h6);
		for (int b = 0; b < 10; b++) begin
			@(posedge pclk); pins <= 10'h1 << b;
			wait3();
			chk(alarm_q, sev_t[b], "severity");
			chk(fw, 11'h1 << b, "fault word");
		end
		@(posedge pclk); pins <= 10'h084;
		wait3(); chk(alarm_q, 32'h5, "or of flags");
		apb(1'b1, ASC_CTRL_OFS, 32'h0);
		@(posedge pclk); pins <= 10'h300;
		wait3(); chk(alarm_q, 32'h0, "supply unfitted");
		@(posedge pclk); pins <= '0;
	endtask
	task t_hw;
		@(posedge pclk); hw_a <= 1'b1;
		wait3(); chk(alarm_q, 32'h4, "clock module");
		@(posedge pclk); hw_a <= 1'b0; hw_b <= 1'b1;
		wait3(); chk(alarm_q, 32'h4, "cpu module");
		@(posedge pclk); hw_b <= 1'b0;
		wait3(); chk(alarm_q, 32'h0, "released");
	endtask
	task t_wander;
		int i;
		apb(1'b1, ASC_CTRL_OFS, 32'h19);
		@(posedge pclk); locked <= 1'b0;
		for (i = 0; i < 1200; i++) begin
			@(posedge pclk); #1;
			if (terr === 32'h3e9) break;
		end
		if (i == 1200) begin num_errors++; test_done(); end
		chk(fw[10], 32'h0, "at limit");
		@(posedge pclk); #1;
		chk(fw[10], 32'h1, "over limit");
		chk(alarm_q, 32'h2, "major same edge");
		chk(ssm, 32'hff0c, "do not use");
		apb(1'b1, ASC_CTRL_OFS, 32'h9);
		@(posedge pclk); #1; chk(ssm, 32'hff20, "option off");
		apb(1'b1, ASC_CTRL_OFS, 32'h11);
		@(posedge pclk); #1; chk(ssm, 32'hff20, "esf off");
		apb(1'b1, ASC_CTRL_OFS, 32'h18);
		@(posedge pclk); #1; chk(fw[10], 32'h0, "no telecom");
		apb(1'b1, ASC_CTRL_OFS, 32'h19);
		@(posedge pclk); #1; chk(fw[10], 32'h1, "telecom back");
		apb(1'b0, ASC_STATUS_OFS, '0);
		chk(rd, 32'h0002_0400, "status word");
		apb(1'b0, ASC_TERR_OFS, '0);
		chk(rd, terr, "drift readback");
		// wander is a level, so relock must clear all three outputs
		@(posedge pclk); locked <= 1'b1;
		wait3(); chk(fw[10], 32'h0, "relock clears");
		chk(alarm_q, 32'h0, "major released");
		chk(ssm, 32'hff20, "sync restored");
	endtask
	// reset, then scenarios in turn
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs(); t_table(); t_hw(); t_wander();
		test_done();
	end
endmodule
`default_nettype wire
